// >>> pwr_params.svh
`ifndef PWR_PARAMS_SVH
`define PWR_PARAMS_SVH

// register word indices, byte address is index times four
`define SLEEP_CTRL_IDX    6'h33
`define MCU_CTRL_IDX      6'h34
`define PWR_REDUCE_IDX    6'h35
`define PWR_STATUS_IDX    6'h36

// sleep mode control fields and reset
`define SLEEP_ARM_BIT     0
`define SLEEP_MODE_LSB    1
`define SLEEP_CTRL_RESET  8'h00

// mcu control fields
`define DEBUG_DIS_BIT     7
`define BOD_OFF_BIT       6
`define BOD_UNLOCK_BIT    5

// sleep mode codes
`define MODE_IDLE         3'h0
`define MODE_ADC_NR       3'h1
`define MODE_POWER_DOWN   3'h2
`define MODE_POWER_SAVE   3'h3
`define MODE_STANDBY      3'h6
`define MODE_EXT_STANDBY  3'h7

// power reduction bit positions
`define GATE_TIMER_TWO    6
`define GATE_CONVERTER    0

// timing in core clock cycles
`define STANDBY_WAKE_CYC  8'h06
`define WAKE_HALT_CYC     8'h04
`define BOD_UNLOCK_CYC    3'h4
`define BOD_OFF_LIFE_CYC  2'h3

`endif

// >>> pwr_pkg.sv
package pwr_pkg;

  typedef enum logic [1:0] {
    st_active,
    st_asleep,
    st_startup,
    st_halt
  } sleep_state_t;

  typedef logic [2:0] sleep_mode_t;

  typedef struct packed {
    logic cpu;
    logic io;
    logic adc;
    logic t2_async;
    logic osc;
  } clock_en_t;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [2:0] win;
    logic [1:0] life;
    logic       unlock;
    logic       brownout_sleep_off;
  } bod_seq_t;

endpackage

// >>> bod_sleep_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwr_params.svh"

module bod_sleep_seq (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // write of the mcu control register
  input  wire logic wr,
  input  wire logic wr_off,
  input  wire logic wr_unlock,
  // state
  output logic      brownout_sleep_off,
  output logic      unlock
);

  pwr_pkg::bod_seq_t s;
  pwr_pkg::bod_seq_t next_s;

  always_comb begin
    next_s = s;
    if (s.win != 3'h0) begin
      next_s.win = s.win - 3'h1;
    end
    if (s.life != 2'h0) begin
      next_s.life = s.life - 2'h1;
    end
    if (next_s.win == 3'h0) begin
      next_s.unlock = 1'b0;
    end
    if (next_s.life == 2'h0) begin
      next_s.brownout_sleep_off = 1'b0; // RL8
    end
    if (wr && wr_off && wr_unlock) begin
      next_s.win    = `BOD_UNLOCK_CYC; // RL6
      next_s.unlock = 1'b1;
    end else if (wr && wr_off && !wr_unlock && s.win != 3'h0) begin
      next_s.brownout_sleep_off   = 1'b1; // RL9
      next_s.life   = `BOD_OFF_LIFE_CYC;
      next_s.unlock = 1'b0;
      next_s.win    = 3'h0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign brownout_sleep_off   = s.brownout_sleep_off;
  assign unlock = s.unlock;

  chk_brownout_sleep_off_self_clear: assert property (@(posedge core_clk) disable iff (!rstn) // RL8
    $rose(s.brownout_sleep_off) |-> s.brownout_sleep_off[*3] ##1 !s.brownout_sleep_off)
    else $error("sleep-off bit did not clear after three cycles");

  chk_brownout_sleep_off_needs_unlock: assert property (@(posedge core_clk) disable iff (!rstn) // RL9
    $rose(s.brownout_sleep_off) |-> $past(s.unlock))
    else $error("sleep-off bit set without unlock step");

endmodule
`default_nettype wire

// >>> periph_clock_gate.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwr_params.svh"

module periph_clock_gate #(
  parameter int N = 8
) (
  // control
  input  wire logic [N-1:0] gate,
  input  wire logic         io_run,
  input  wire logic         t2_async,
  // per peripheral
  output logic [N-1:0]      clk_en,
  output logic [N-1:0]      access_ok
);

  initial begin
    if (N <= `GATE_TIMER_TWO) begin
      $error("periph_clock_gate needs the timer two position");
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      if (i == `GATE_TIMER_TWO) begin : g_t2
        // the async timer keeps its own oscillator, gating has no hold on it
        assign clk_en[i]    = t2_async || (io_run && !gate[i]); // RL14
        assign access_ok[i] = t2_async || !gate[i];
      end else begin : g_std
        assign clk_en[i]    = io_run && !gate[i]; // RL10 RL11 RL12
        assign access_ok[i] = !gate[i];
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> sleep_and_power_reduction_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwr_params.svh"

// Overview of operation
// RL1 - mode 110 with crystal: standby, six-cycle wake
// RL2 - mode 111 with crystal: extended standby, six-cycle wake
// RL3 - mode field encodes six modes, two reserved
// RL4 - sleep happens only while arm bit set
// RL5 - software arms just before, disarms after
// RL6 - sleep-off set needs unlock write within four
// RL7 - sleep-off effective turns detector off in sleep; code turns it off only in deep sleep, not in idle or ADC noise reduction
// RL8 - sleep-off clears itself after three cycles
// RL9 - no unlock step, no sleep-off set
// RL10 - gate bit stops peripheral clock and access
// RL11 - clearing gate resumes peripheral unchanged
// RL12 - gating matters only in active and idle
// RL13 - gate bits seven to zero map peripherals
// RL14 - timer two gated only in synchronous use
// RL15 - gated converter denies comparator the mux
// RL16 - software reinitialises serial modules after ungating
// RL17 - deep sleep disables input buffers except wake
// RL18 - debug keeps main clock unless disabled
// RL19 - converter stays on; restart gives extended conversion
// RL20 - comparator off in deep sleep unless bandgap
// RL21 - watchdog and detector keep running in sleep
// RL22 - interrupt wake halts four extra cycles
// RL23 - power-down halts all generated clocks
// RL24 - upper four mode register bits read zero
module sleep_and_power_reduction_ctrl #(
  parameter int STARTUP_CYCLES = 16,
  parameter int N_PINS         = 32
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // wishbone slave
  input  wire logic              wb_cyc,
  input  wire logic              wb_stb,
  input  wire logic              wb_we,
  input  wire logic [3:0]        wb_sel,
  input  wire logic [7:0]        wb_adr,
  input  wire logic [31:0]       wb_dat_i,
  output logic                   wb_ack,
  output logic [31:0]            wb_dat_o,
  // core events
  input  wire logic              sleep_instr,
  input  wire logic              wake_req,
  // fuses and clock option
  input  wire logic              crystal_sel,
  input  wire logic              onchip_debug_fuse,
  input  wire logic              scan_port_fuse,
  input  wire logic              brownout_level_fuse,
  // peripheral status
  input  wire logic              timer_two_async_select,
  input  wire logic              adc_enable,
  input  wire logic              adc_conv_start,
  input  wire logic              comparator_bandgap,
  input  wire logic [N_PINS-1:0] wake_pin_mask,
  // clock and power controls
  output pwr_pkg::clock_en_t     clk_en,
  output logic [7:0]             periph_clk_en,
  output logic [7:0]             periph_access,
  output logic                   bod_run,
  output logic                   comparator_off,
  output logic                   adc_mux_avail,
  output logic                   adc_power,
  output logic                   adc_extended_next,
  output logic [N_PINS-1:0]      input_buf_en,
  output logic                   wake_resume
);

  initial begin
    if (STARTUP_CYCLES < 2 || STARTUP_CYCLES > 255) begin
      $error("STARTUP_CYCLES must lie in 2..255");
    end
    if (N_PINS < 1) begin
      $error("N_PINS must be at least one");
    end
  end

  localparam logic [7:0] STARTUP_CNT = 8'(STARTUP_CYCLES);

  typedef struct packed {
    pwr_pkg::sleep_state_t state;
    logic [7:0]            cnt;
    pwr_pkg::sleep_mode_t  mode;
    logic                  arm;
    pwr_pkg::sleep_mode_t  slp_mode;
    logic                  dbg_dis;
    logic [7:0]            gate;
    logic                  bod_off;
    logic                  ack;
    logic [31:0]           rdata;
    pwr_pkg::clock_en_t    clk;
    logic [7:0]            pclk;
    logic [7:0]            pacc;
    logic                  bod_run;
    logic                  comp_off;
    logic                  mux_ok;
    logic                  adc_pwr;
    logic                  adc_prev;
    logic                  adc_ext;
    logic [N_PINS-1:0]     inbuf;
    logic                  resume;
  } ctrl_t;

  ctrl_t s;
  ctrl_t next_s;

  logic brownout_sleep_off;
  logic bod_unlock;
  logic mcu_wr;
  logic [7:0] pclk_c;
  logic [7:0] pacc_c;

  function automatic logic hit(input logic [7:0] adr, input logic [5:0] idx);
    hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  // modes that stop both the io and converter clocks
  function automatic logic deep(input pwr_pkg::sleep_mode_t m);
    deep = (m != `MODE_IDLE) && (m != `MODE_ADC_NR);
  endfunction

  function automatic logic mode_ok(input pwr_pkg::sleep_mode_t m);
    mode_ok = (m != 3'h4) && (m != 3'h5); // RL3
  endfunction

  function automatic pwr_pkg::clock_en_t clocks(
      input pwr_pkg::sleep_state_t st,
      input pwr_pkg::sleep_mode_t  m,
      input logic                  t2a,
      input logic                  keep_osc);
    pwr_pkg::clock_en_t c;
    c = '0;
    case (st)
      pwr_pkg::st_active: begin
        c = '1;
      end
      pwr_pkg::st_asleep: begin
        case (m)
          `MODE_IDLE: begin
            c.io       = 1'b1;
            c.adc      = 1'b1;
            c.t2_async = 1'b1;
            c.osc      = 1'b1;
          end
          `MODE_ADC_NR: begin
            c.adc      = 1'b1;
            c.t2_async = 1'b1;
            c.osc      = 1'b1;
          end
          `MODE_POWER_SAVE: begin
            c.t2_async = t2a;
          end
          `MODE_STANDBY: begin
            c.osc = 1'b1; // RL1
          end
          `MODE_EXT_STANDBY: begin
            c.t2_async = t2a; // RL2
            c.osc      = 1'b1;
          end
          default: begin
            c = '0; // RL23
          end
        endcase
        c.osc = c.osc || keep_osc; // RL18
      end
      pwr_pkg::st_startup: begin
        c.osc      = 1'b1;
        c.t2_async = t2a;
      end
      default: begin
        // halted core while peripherals already run again
        c.io       = 1'b1;
        c.adc      = 1'b1;
        c.t2_async = 1'b1;
        c.osc      = 1'b1;
      end
    endcase
    clocks = c;
  endfunction

  assign mcu_wr = wb_cyc && wb_stb && !s.ack && wb_we && wb_sel[0]
                  && hit(wb_adr, `MCU_CTRL_IDX);

  bod_sleep_seq u_bod (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .wr        (mcu_wr),
    .wr_off    (wb_dat_i[`BOD_OFF_BIT]),
    .wr_unlock (wb_dat_i[`BOD_UNLOCK_BIT]),
    .brownout_sleep_off      (brownout_sleep_off),
    .unlock    (bod_unlock)
  );

  periph_clock_gate #(
    .N (8)
  ) u_gate (
    .gate      (next_s.gate),
    .io_run    (next_s.clk.io),
    .t2_async  (timer_two_async_select),
    .clk_en    (pclk_c),
    .access_ok (pacc_c)
  );

  always_comb begin
    logic wr;
    logic keep_osc;
    pwr_pkg::sleep_mode_t m;
    wr       = 1'b0;
    keep_osc = 1'b0;
    m        = s.mode;
    next_s   = s;
    next_s.resume = 1'b0;

    // bus slave, one wait state, unmapped reads give zero
    next_s.ack   = wb_cyc && wb_stb && !s.ack;
    wr           = next_s.ack && wb_we && wb_sel[0];
    next_s.rdata = 32'h0000_0000;
    if (next_s.ack && !wb_we) begin
      if (hit(wb_adr, `SLEEP_CTRL_IDX)) begin
        next_s.rdata = {28'h000_0000, s.mode, s.arm}; // RL24
      end else if (hit(wb_adr, `MCU_CTRL_IDX)) begin
        next_s.rdata = {24'h00_0000, s.dbg_dis, brownout_sleep_off, bod_unlock, 5'h00};
      end else if (hit(wb_adr, `PWR_REDUCE_IDX)) begin
        next_s.rdata = {24'h00_0000, s.gate};
      end else if (hit(wb_adr, `PWR_STATUS_IDX)) begin
        next_s.rdata = {24'h00_0000, 2'h0, s.bod_off, 2'(s.state), s.slp_mode};
      end
    end
    if (wr && hit(wb_adr, `SLEEP_CTRL_IDX)) begin
      next_s.mode = wb_dat_i[`SLEEP_MODE_LSB +: 3];
      next_s.arm  = wb_dat_i[`SLEEP_ARM_BIT]; // RL5
    end
    if (wr && hit(wb_adr, `MCU_CTRL_IDX)) begin
      next_s.dbg_dis = wb_dat_i[`DEBUG_DIS_BIT]; // RL18
    end
    if (wr && hit(wb_adr, `PWR_REDUCE_IDX)) begin
      next_s.gate = wb_dat_i[7:0]; // RL13
    end

    // without a crystal the standby modes fall back to their base modes
    if (!crystal_sel && s.mode[2]) begin
      m = {1'b0, s.mode[1:0]};
    end

    case (s.state)
      pwr_pkg::st_active: begin
        if (sleep_instr && s.arm && mode_ok(s.mode)) begin // RL4
          next_s.state    = pwr_pkg::st_asleep;
          next_s.slp_mode = m;
          next_s.bod_off  = brownout_sleep_off && deep(m); // RL7
        end
      end
      pwr_pkg::st_asleep: begin
        if (wake_req) begin
          next_s.bod_off = 1'b0;
          if (!deep(s.slp_mode)) begin
            next_s.state = pwr_pkg::st_halt;
            next_s.cnt   = `WAKE_HALT_CYC;
          end else begin
            next_s.state = pwr_pkg::st_startup;
            next_s.cnt   = s.slp_mode[2] ? `STANDBY_WAKE_CYC : STARTUP_CNT; // RL1 RL2
          end
        end
      end
      pwr_pkg::st_startup: begin
        if (s.cnt == 8'h01) begin
          next_s.state = pwr_pkg::st_halt;
          next_s.cnt   = `WAKE_HALT_CYC; // RL22
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      pwr_pkg::st_halt: begin
        if (s.cnt == 8'h01) begin
          next_s.state  = pwr_pkg::st_active;
          next_s.cnt    = 8'h00;
          next_s.resume = 1'b1; // RL22
        end else begin
          next_s.cnt = s.cnt - 8'h01;
        end
      end
      default: begin
        next_s.state = pwr_pkg::st_active;
      end
    endcase

    keep_osc = onchip_debug_fuse && scan_port_fuse && !next_s.dbg_dis;
    next_s.clk = clocks(next_s.state, next_s.slp_mode, timer_two_async_select,
                        keep_osc);
    next_s.pclk = pclk_c;
    next_s.pacc = pacc_c;

    // detector runs in every sleep unless switched off for this one
    next_s.bod_run = brownout_level_fuse
                     && !(next_s.state == pwr_pkg::st_asleep && next_s.bod_off); // RL21

    next_s.comp_off = next_s.state == pwr_pkg::st_asleep
                      && deep(next_s.slp_mode) && !comparator_bandgap; // RL20
    next_s.mux_ok   = !next_s.gate[`GATE_CONVERTER]; // RL15

    next_s.adc_pwr  = adc_enable; // RL19
    next_s.adc_prev = adc_enable;
    if (adc_conv_start) begin
      next_s.adc_ext = 1'b0;
    end
    if (s.adc_prev && !adc_enable) begin
      next_s.adc_ext = 1'b1; // RL19
    end

    if (next_s.clk.io || next_s.clk.adc) begin
      next_s.inbuf = '1;
    end else begin
      next_s.inbuf = wake_pin_mask; // RL17
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s       <= '0;
      s.state <= pwr_pkg::st_active;
      s.clk   <= '1;
      s.pclk  <= 8'hFF;
      s.pacc  <= 8'hFF;
      s.mux_ok <= 1'b1;
      s.inbuf <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack            = s.ack;
  assign wb_dat_o          = s.rdata;
  assign clk_en            = s.clk;
  assign periph_clk_en     = s.pclk;
  assign periph_access     = s.pacc;
  assign bod_run           = s.bod_run;
  assign comparator_off    = s.comp_off;
  assign adc_mux_avail     = s.mux_ok;
  assign adc_power         = s.adc_pwr;
  assign adc_extended_next = s.adc_ext;
  assign input_buf_en      = s.inbuf;
  assign wake_resume       = s.resume;

  sequence halt_then_run;
    (s.state == pwr_pkg::st_halt)[*4] ##1 (s.state == pwr_pkg::st_active);
  endsequence

  sequence standby_wake;
    s.state == pwr_pkg::st_asleep && wake_req && s.slp_mode[2];
  endsequence

  chk_standby_six_cycles: assert property (@(posedge core_clk) disable iff (!rstn) // RL1
    standby_wake |=> (s.state == pwr_pkg::st_startup)[*6] ##1 halt_then_run)
    else $error("standby wake did not take six cycles");

  chk_wake_halt_four: assert property (@(posedge core_clk) disable iff (!rstn) // RL22
    $rose(s.state == pwr_pkg::st_halt) |-> halt_then_run ##0 s.resume)
    else $error("wake halt was not four cycles");

  chk_sleep_needs_arm: assert property (@(posedge core_clk) disable iff (!rstn) // RL4
    s.state == pwr_pkg::st_active && sleep_instr && !s.arm
    |=> s.state == pwr_pkg::st_active)
    else $error("sleep entered without arm bit");

  chk_reserved_no_sleep: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
    s.state == pwr_pkg::st_active && sleep_instr && s.mode[2:1] == 2'b10
    |=> s.state == pwr_pkg::st_active)
    else $error("reserved mode entered sleep");

  chk_powerdown_clocks: assert property (@(posedge core_clk) disable iff (!rstn) // RL23
    s.state == pwr_pkg::st_asleep && s.slp_mode == `MODE_POWER_DOWN
    |-> !s.clk.cpu && !s.clk.io && !s.clk.adc && !s.clk.t2_async)
    else $error("clock running in power-down");

  chk_bod_off_sleep: assert property (@(posedge core_clk) disable iff (!rstn) // RL7
    s.state == pwr_pkg::st_active && sleep_instr && s.arm && brownout_sleep_off
    && s.mode == `MODE_POWER_DOWN |=> !s.bod_run ##0 s.state == pwr_pkg::st_asleep)
    else $error("detector not off for armed sleep");

  chk_gate_resume: assert property (@(posedge core_clk) disable iff (!rstn) // RL11
    $fell(s.gate[5]) && s.clk.io |-> s.pclk[5] && s.pacc[5])
    else $error("ungated peripheral clock did not restart");

  chk_inbuf_deep: assert property (@(posedge core_clk) disable iff (!rstn) // RL17
    !s.clk.io && !s.clk.adc |-> (s.inbuf & ~$past(wake_pin_mask)) == '0)
    else $error("input buffer on in deep sleep");

  chk_mode_upper_zero: assert property (@(posedge core_clk) disable iff (!rstn) // RL24
    $rose(s.ack) && !wb_we && hit(wb_adr, `SLEEP_CTRL_IDX) |-> s.rdata[31:4] == 28'h0)
    else $error("upper mode register bits not zero");

endmodule
`default_nettype wire

// >>> test_sleep_and_power_reduction_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwr_params.svh"

module test_sleep_and_power_reduction_ctrl;
  localparam int SU = 4;
  localparam logic [2:0] MODES [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  localparam logic [7:0] REFUSE [3] = '{8'h04, 8'h09, 8'h0B};

  logic               core_clk;
  logic               rstn;
  logic               wb_cyc;
  logic               wb_stb;
  logic               wb_we;
  logic               wb_ack;
  logic [7:0]         wb_adr;
  logic [31:0]        wb_dat_i;
  logic [31:0]        wb_dat_o;
  logic               sleep_instr;
  logic               wake_req;
  logic               crystal;
  logic               dbg;
  logic               async2;
  logic               adc_en;
  logic               conv;
  logic               bgap;
  logic [31:0]        pins;
  pwr_pkg::clock_en_t ce;
  logic [7:0]         pce;
  logic [7:0]         pac;
  logic               bod_run;
  logic               cmp_off;
  logic               mux;
  logic               adc_power;
  logic               ext;
  logic [31:0]        ibe;
  logic               wake_resume;
  logic [31:0]        seed;
  logic [7:0]         q;
  int                 miscompares;
  int                 checked;
  int                 cycles;

  sleep_and_power_reduction_ctrl #(.STARTUP_CYCLES(SU), .N_PINS(32)) u_sleep_and_power_reduction_ctrl (
    .core_clk(core_clk), .rstn(rstn),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_sel(4'h1), .wb_adr(wb_adr),
    .wb_dat_i(wb_dat_i), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
    .sleep_instr(sleep_instr), .wake_req(wake_req), .crystal_sel(crystal),
    .onchip_debug_fuse(dbg), .scan_port_fuse(dbg), .brownout_level_fuse(1'b1),
    .timer_two_async_select(async2), .adc_enable(adc_en), .adc_conv_start(conv),
    .comparator_bandgap(bgap), .wake_pin_mask(pins),
    .clk_en(ce), .periph_clk_en(pce), .periph_access(pac), .bod_run(bod_run),
    .comparator_off(cmp_off), .adc_mux_avail(mux), .adc_power(adc_power),
    .adc_extended_next(ext), .input_buf_en(ibe), .wake_resume(wake_resume)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected {cpu, io, adc, osc} while asleep
  function automatic logic [3:0] exp_clk(logic [2:0] m, logic x, logic d);
    return {1'b0, m == 3'h0, m <= 3'h1, (m <= 3'h1) | (m[2] & x) | d};
  endfunction

  function automatic int exp_wake(logic [2:0] m, logic x);
    if (m <= 3'h1)
      return 5;
    return ((m[2] & x) ? 6 : SU) + 5;
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one classic cycle; returns at the edge that saw ack, read data in q
  task automatic wb(logic we, logic [5:0] idx, logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_dat_i <= {24'h0, d};
    // ack is looked at mid-cycle, where it has settled, and the request is released
    // at the next rising edge, the edge at which the slave samples it with ack high
    do begin
      @(negedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("ERROR wb_ack expected 1 seen timeout");
    end
    q = wb_dat_o[7:0];
    @(posedge core_clk);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic sleep_now();
    sleep_instr <= 1'b1;
    @(posedge core_clk);
    sleep_instr <= 1'b0;
    @(negedge core_clk);
  endtask

  task automatic wake_count(output int n);
    n = 0;
    @(posedge core_clk);
    wake_req <= 1'b1;
    do begin
      @(posedge core_clk);
      wake_req <= 1'b0;
      n++;
      #1;
    end while (wake_resume !== 1'b1 && n < 300);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    int n;
    logic [31:0] r;
    logic [7:0] g;
    seed = 32'h80CE;
    {wb_cyc, wb_stb, wb_we, sleep_instr, wake_req, crystal, dbg} = 7'h00;
    {async2, adc_en, conv, bgap} = 4'h0;
    {wb_adr, wb_dat_i, pins} = '0;
    {miscompares, checked, cycles} = '0;
    rstn = 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    check("clk_en", ce, 5'h1F);
    check("bod_run", bod_run, 1);
    wb(1'b0, `SLEEP_CTRL_IDX, 8'h00);
    check("sleep_mode_control_reset", q, `SLEEP_CTRL_RESET);
    wb(1'b1, 6'h3F, 8'hFF);
    wb(1'b0, 6'h3F, 8'h00);
    check("unmapped", q, 0);
    repeat (4) begin
      r = rnd();
      wb(1'b1, `SLEEP_CTRL_IDX, r[7:0]);
      wb(1'b0, `SLEEP_CTRL_IDX, 8'h00);
      check("sleep_mode_control", q, {28'h0, r[3:0]});
    end
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      g = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[7:0];
      async2 <= r[8];
      wb(1'b1, `PWR_REDUCE_IDX, g);
      @(negedge core_clk);
      check("periph_clk_en", pce, {24'h0, ~g | {1'b0, r[8], 6'h0}});
      check("periph_access", pac, {24'h0, ~g | {1'b0, r[8], 6'h0}});
      check("adc_mux_avail", mux, !g[0]);
      wb(1'b0, `PWR_REDUCE_IDX, 8'h00);
      check("prr", q, g);
    end
    async2 <= 1'b0;
    wb(1'b1, `PWR_REDUCE_IDX, 8'h00);
    @(negedge core_clk);
    check("periph_clk_en", pce, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `SLEEP_CTRL_IDX, REFUSE[i]);
      sleep_now();
      check("cpu_clk", ce.cpu, 1);
    end
    adc_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      g = r[15:8];
      crystal <= r[0];
      bgap <= r[1];
      pins <= r;
      wb(1'b1, `PWR_REDUCE_IDX, g);
      wb(1'b1, `SLEEP_CTRL_IDX, {4'h0, MODES[i], 1'b1});
      sleep_now();
      check("clk_en", {ce.cpu, ce.io, ce.adc, ce.osc}, exp_clk(MODES[i], r[0], 1'b0));
      check("input_buf_en", ibe, (MODES[i] > 3'h1) ? r : 32'hFFFFFFFF);
      check("comparator_off", cmp_off, (MODES[i] > 3'h1) & ~r[1]);
      check("adc_power", adc_power, 1);
      check("bod_run", bod_run, 1);
      if (MODES[i] == 3'h0)
        check("periph_clk_en", pce, {24'h0, ~g});
      wake_count(n);
      check("wake_cycles", n, exp_wake(MODES[i], r[0]));
      check("cpu_clk", ce.cpu, 1);
      wb(1'b1, `SLEEP_CTRL_IDX, 8'h00);
    end
    wb(1'b1, `PWR_REDUCE_IDX, 8'h00);
    wb(1'b1, `SLEEP_CTRL_IDX, {4'h0, `MODE_POWER_DOWN, 1'b1});
    wb(1'b1, `MCU_CTRL_IDX, 8'h60);
    wb(1'b1, `MCU_CTRL_IDX, 8'h40);
    sleep_now();
    check("bod_run", bod_run, 0);
    wake_count(n);
    check("wake_cycles", n, SU + 5);
    check("bod_run", bod_run, 1);
    wb(1'b1, `MCU_CTRL_IDX, 8'h60);
    repeat (5) @(posedge core_clk);
    wb(1'b1, `MCU_CTRL_IDX, 8'h40);
    sleep_now();
    check("bod_run", bod_run, 1);
    wake_count(n);
    wb(1'b1, `MCU_CTRL_IDX, 8'h40);
    sleep_now();
    check("bod_run", bod_run, 1);
    wake_count(n);
    wb(1'b1, `MCU_CTRL_IDX, 8'h60);
    wb(1'b1, `MCU_CTRL_IDX, 8'h40);
    wb(1'b0, `MCU_CTRL_IDX, 8'h00);
    check("sleep_off", q[6], 1);
    wb(1'b0, `MCU_CTRL_IDX, 8'h00);
    check("sleep_off", q[6], 0);
    dbg <= 1'b1;
    sleep_now();
    check("osc", ce.osc, 1);
    wake_count(n);
    wb(1'b1, `MCU_CTRL_IDX, 8'h80);
    sleep_now();
    check("osc", ce.osc, 0);
    wake_count(n);
    wb(1'b1, `SLEEP_CTRL_IDX, 8'h00);
    @(posedge core_clk);
    adc_en <= 1'b0;
    @(posedge core_clk);
    adc_en <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check("adc_extended_next", ext, 1);
    @(posedge core_clk);
    conv <= 1'b1;
    @(posedge core_clk);
    conv <= 1'b0;
    @(negedge core_clk);
    check("adc_extended_next", ext, 0);
    test_done();
  end
endmodule

`default_nettype wire
